// ===== common/ssp_regs.vh
`ifndef SSP_REGS_VH
`define SSP_REGS_VH

// ****************************************************************
// Frame layout
// ****************************************************************
`define SSP_FRAME_BITS 6'd32
`define SSP_DATA_MSB 31
`define SSP_DATA_LSB 8
`define SSP_RADDR_MSB 7
`define SSP_RADDR_LSB 3
`define SSP_CHIP_MSB 2
`define SSP_CHIP_LSB 0
`define SSP_OWN_CHIP 3'h0

// ****************************************************************
// Register indices
// ****************************************************************
`define SSP_REG_READ_SELECT 5'h00
`define SSP_REG_POWER 5'h01
`define SSP_REG_FRAC 5'h04
`define SSP_REG_SEED 5'h06
`define SSP_REG_DRIVER 5'h08
`define SSP_REG_PIN_CTL 5'h0f
`define SSP_LAST_ADDR 5'h1f

// ****************************************************************
// Field positions
// ****************************************************************
`define SSP_RDSEL_MSB 4
`define SSP_RDSEL_LSB 0
`define SSP_SOFT_RESET_BIT 5
`define SSP_PIN_SELECT_BIT 0
`define SSP_SPI_ENABLE_BIT 1
`define SSP_KEEP_MSB 7
`define SSP_KEEP_LSB 2
`define SSP_SEED_MSB 1
`define SSP_SEED_LSB 0
`define SSP_MASTER_DRV_BIT 5
`define SSP_GPO_SEL_MSB 4
`define SSP_GPO_SEL_LSB 0
`define SSP_AUTOMUX_DIS_BIT 6
`define SSP_ALWAYS_ON_BIT 7
`define SSP_PULLUP_DIS_BIT 8
`define SSP_PULLDN_DIS_BIT 9

// ****************************************************************
// Reset values
// ****************************************************************
`define SSP_POWER_DEFAULT 24'h000002
`define SSP_SEED_DEFAULT 24'h000000
`define SSP_DRIVER_DEFAULT 24'h000020
`define SSP_PIN_CTL_DEFAULT 24'h000001
`define SSP_MEM_DEFAULT 24'h000000
`define SSP_PART_ID 24'h5a5a01

// ****************************************************************
// Timing
// ****************************************************************
`define SSP_CLK_MHZ 125
`define SSP_POR_TIME_US 250
`define SSP_LOAD_DELAY 2'h3

`endif

// ===== rtl/ssp_sync.v
`timescale 1ns/100ps
`include "ssp_regs.vh"

// Two-flop synchroniser; edges are found from the second and third stages only.
// The reset level should equal the idle level of the pin, or a false edge follows reset.
module ssp_sync #(
    parameter RESET_LEVEL = 1'b0
) (
    input wire clk,
    input wire rst_n,
    input wire din,
    output wire level,
    output wire rise,
    output wire fall
);
    reg meta_reg;
    reg sync_reg;
    reg prev_reg;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= RESET_LEVEL;
            sync_reg <= RESET_LEVEL;
            prev_reg <= RESET_LEVEL;
        end else begin
            meta_reg <= din;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    assign level = sync_reg;
    assign rise = sync_reg & ~prev_reg;
    assign fall = ~sync_reg & prev_reg;
endmodule

// ===== rtl/ssp_regmem.v
`timescale 1ns/100ps
`include "ssp_regs.vh"

// Register store with registered read data.
module ssp_regmem #(
    parameter AW = 5,
    parameter DW = 24
) (
    input wire clk,
    input wire wr_en,
    input wire [AW-1:0] wr_addr,
    input wire [DW-1:0] wr_data,
    input wire [AW-1:0] rd_addr,
    output reg [DW-1:0] rd_data
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    always @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule

// ===== rtl/ssp_top.v
`timescale 1ns/100ps
`include "ssp_regs.vh"

//Contract
//RULE1: Data word, 24 bits MSB first.
//RULE2: Then 5-bit register address, MSB first.
//RULE3: Frame ends with 3-bit chip address.
//RULE4: Chip address 000 addresses this device.
//RULE5: Strobe rising edge commits shifted frame.
//RULE6: Each frame outputs register chosen by read-select.
//RULE7: Host reads by writing target to register 0.
//RULE8: Driver high impedance after reset.
//RULE9: Drive after strobe when chip bits zero.
//RULE10: Always-on bit keeps driver enabled.
//RULE11: Auto-mux disable keeps general-purpose signal.
//RULE12: Master driver bit zero disables everything.
//RULE13: Pull-up and pull-down halves separately disabled.
//RULE14: Five-bit select picks general-purpose signal.
//RULE15: Soft reset restores synthesizer control defaults.
//RULE16: Defaults loaded 250 us after power-up.
//RULE17: Pin-select chooses pin or software power-down.
//RULE18: Serial port keeps working while powered down.
//RULE19: Keep-on bits hold blocks active.
//RULE20: Seed reloaded on each new fraction.
//RULE21: Host computes integer, step and fraction.
//RULE22: Host serial clock up to 50 MHz.
//RULE23: Pin reverts to lock detect after strobe.
//RULE24: Frames for other chips are ignored.
//RULE25: Only addressed register updated, all bits.
module ssp_top #(
    parameter POR_CYCLES = `SSP_POR_TIME_US * `SSP_CLK_MHZ,
    parameter [23:0] PART_ID = `SSP_PART_ID
) (
    input wire clk,
    input wire rst_n,
    input wire serial_clk,
    input wire serial_data_in,
    input wire frame_strobe,
    input wire chip_enable_pin,
    input wire [31:0] gpo_sources,
    output wire shared_lock_readback_pin_o,
    output wire shared_lock_readback_pin_oe,
    output wire powered_down,
    output wire [5:0] block_enable,
    output wire [1:0] fractional_seed,
    output reg fractional_seed_reload,
    output wire port_ready
);
    // Part identifier value is arbitrary.

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function is_flop_reg;
        input [4:0] a;
        begin
            is_flop_reg = (a == `SSP_REG_READ_SELECT) || (a == `SSP_REG_POWER) || (a == `SSP_REG_SEED) ||
                (a == `SSP_REG_DRIVER) || (a == `SSP_REG_PIN_CTL);
        end
    endfunction

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    wire sck_rise;
    wire sck_fall;
    wire sdi_s;
    wire sen_s;
    wire sen_rise;
    wire sen_fall;
    wire cen_s;

    ssp_sync u_sck (.clk(clk), .rst_n(rst_n), .din(serial_clk), .level(), .rise(sck_rise), .fall(sck_fall));
    ssp_sync u_sdi (.clk(clk), .rst_n(rst_n), .din(serial_data_in), .level(sdi_s), .rise(), .fall());
    // The strobe idles high between frames, so its stages reset high.
    // A low reset value would show a strobe edge just after reset and arm the pin driver.
    ssp_sync #(
        .RESET_LEVEL(1'b1)
    ) u_sen (
        .clk(clk),
        .rst_n(rst_n),
        .din(frame_strobe),
        .level(sen_s),
        .rise(sen_rise),
        .fall(sen_fall)
    );
    ssp_sync u_cen (.clk(clk), .rst_n(rst_n), .din(chip_enable_pin), .level(cen_s), .rise(), .fall());

    // ****************************************************************
    // Power-on default load
    // ****************************************************************
    // The counter delays the full default load; it is a parameter so benches can shorten it.
    reg [31:0] por_cnt_reg;
    reg por_done_reg;
    reg sweep_active_reg;
    reg [4:0] sweep_addr_reg;
    wire sweep_start;
    wire soft_reset;
    wire commit;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            por_cnt_reg <= 32'h0;
            por_done_reg <= 1'b0;
        end else if (!por_done_reg) begin
            if (por_cnt_reg >= POR_CYCLES - 1) begin
                por_done_reg <= 1'b1; // RULE16
            end else begin
                por_cnt_reg <= por_cnt_reg + 32'h1;
            end
        end
    end

    assign sweep_start = (!por_done_reg && por_cnt_reg >= POR_CYCLES - 1) || soft_reset;

    // The sweep writes defaults into every memory word, one per cycle.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sweep_active_reg <= 1'b0;
            sweep_addr_reg <= 5'h0;
        end else if (sweep_start) begin
            sweep_active_reg <= 1'b1; // RULE15 RULE16
            sweep_addr_reg <= 5'h0;
        end else if (sweep_active_reg) begin
            sweep_addr_reg <= sweep_addr_reg + 5'h1;
            if (sweep_addr_reg == `SSP_LAST_ADDR) begin
                sweep_active_reg <= 1'b0;
            end
        end
    end

    // Serial activity is still shifted during the load, but a strobe before it ends commits nothing.
    assign port_ready = por_done_reg & ~sweep_active_reg;

    // ****************************************************************
    // Frame shifter
    // ****************************************************************
    reg [31:0] shift_reg;
    reg [5:0] bit_cnt_reg;
    wire [23:0] frame_data = shift_reg[`SSP_DATA_MSB:`SSP_DATA_LSB];
    wire [4:0] frame_raddr = shift_reg[`SSP_RADDR_MSB:`SSP_RADDR_LSB];
    wire [2:0] frame_chip = shift_reg[`SSP_CHIP_MSB:`SSP_CHIP_LSB];
    wire addressed = (frame_chip == `SSP_OWN_CHIP);

    // Bits enter at the LSB of the shifter, so the first bit ends up at the MSB of the data word.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_reg <= 32'h0;
            bit_cnt_reg <= 6'h0;
        end else if (sen_rise) begin
            shift_reg <= 32'h0;
            bit_cnt_reg <= 6'h0;
        end else if (sck_rise && !sen_s) begin
            shift_reg <= {shift_reg[30:0], sdi_s}; // RULE1 RULE2 RULE3
            // The count stops at a full frame; extra clocks only push older bits out of the shifter.
            if (bit_cnt_reg != `SSP_FRAME_BITS) begin
                bit_cnt_reg <= bit_cnt_reg + 6'h1;
            end
        end
    end

    // Short frames, frames for another chip and frames during the default load are all dropped.
    assign commit = sen_rise && port_ready && addressed && (bit_cnt_reg == `SSP_FRAME_BITS); // RULE5 RULE4 RULE24

    // ****************************************************************
    // Registers
    // ****************************************************************
    reg [4:0] rd_sel_reg;
    reg [23:0] power_reg;
    reg [23:0] seed_ctl_reg;
    reg [23:0] driver_reg;
    reg [23:0] pin_ctl_reg;

    assign soft_reset = commit && (frame_raddr == `SSP_REG_READ_SELECT) && frame_data[`SSP_SOFT_RESET_BIT];

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_sel_reg <= 5'h0;
            power_reg <= `SSP_POWER_DEFAULT;
            seed_ctl_reg <= `SSP_SEED_DEFAULT;
            driver_reg <= `SSP_DRIVER_DEFAULT;
            pin_ctl_reg <= `SSP_PIN_CTL_DEFAULT;
            fractional_seed_reload <= 1'b0;
        end else begin
            fractional_seed_reload <= 1'b0;
            if (sweep_start) begin
                // Soft reset restores control words; the read selector is serial-port state and stays.
                power_reg <= `SSP_POWER_DEFAULT; // RULE15
                seed_ctl_reg <= `SSP_SEED_DEFAULT;
                driver_reg <= `SSP_DRIVER_DEFAULT;
                pin_ctl_reg <= `SSP_PIN_CTL_DEFAULT; // RULE14
                if (!por_done_reg) begin
                    rd_sel_reg <= 5'h0;
                end
            end else if (commit) begin
                case (frame_raddr) // RULE25
                    `SSP_REG_READ_SELECT: rd_sel_reg <= frame_data[`SSP_RDSEL_MSB:`SSP_RDSEL_LSB]; // RULE7
                    `SSP_REG_POWER: power_reg <= frame_data;
                    `SSP_REG_SEED: seed_ctl_reg <= frame_data;
                    `SSP_REG_DRIVER: driver_reg <= frame_data;
                    `SSP_REG_PIN_CTL: pin_ctl_reg <= frame_data;
                    `SSP_REG_FRAC: fractional_seed_reload <= 1'b1; // RULE20
                    default: fractional_seed_reload <= 1'b0;
                endcase
            end
        end
    end

    // Words that are not held in flops live in the memory; the sweep owns its write port while it runs.
    wire mem_we = sweep_active_reg || (commit && !is_flop_reg(frame_raddr));
    wire [4:0] mem_waddr = sweep_active_reg ? sweep_addr_reg : frame_raddr;
    wire [23:0] mem_wdata = sweep_active_reg ? `SSP_MEM_DEFAULT : frame_data;
    wire [23:0] mem_rdata;

    ssp_regmem #(.AW(5), .DW(24)) u_mem (
        .clk(clk),
        .wr_en(mem_we),
        .wr_addr(mem_waddr),
        .wr_data(mem_wdata),
        .rd_addr(rd_sel_reg),
        .rd_data(mem_rdata)
    );

    assign fractional_seed = seed_ctl_reg[`SSP_SEED_MSB:`SSP_SEED_LSB]; // RULE20

    // ****************************************************************
    // Power-down selection
    // ****************************************************************
    // Only analog enables follow power-down; the serial logic runs on clk regardless.
    assign powered_down = power_reg[`SSP_PIN_SELECT_BIT] ? ~cen_s : ~power_reg[`SSP_SPI_ENABLE_BIT]; // RULE17 RULE18
    assign block_enable = {6{~powered_down}} | power_reg[`SSP_KEEP_MSB:`SSP_KEEP_LSB]; // RULE19

    // ****************************************************************
    // Readback path
    // ****************************************************************
    reg [23:0] rb_word;
    reg [23:0] out_sr_reg;
    reg [1:0] load_cnt_reg;
    reg drive_reg;
    reg in_frame_reg;

    always @* begin
        case (rd_sel_reg) // RULE6
            `SSP_REG_READ_SELECT: rb_word = PART_ID;
            `SSP_REG_POWER: rb_word = power_reg;
            `SSP_REG_SEED: rb_word = seed_ctl_reg;
            `SSP_REG_DRIVER: rb_word = driver_reg;
            `SSP_REG_PIN_CTL: rb_word = pin_ctl_reg;
            default: rb_word = mem_rdata;
        endcase
    end

    // The word is loaded a few cycles after the strobe so a new read selector has reached the memory output.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_sr_reg <= 24'h0;
            load_cnt_reg <= 2'h0;
            drive_reg <= 1'b0; // RULE8
            in_frame_reg <= 1'b0;
        end else begin
            if (sen_rise) begin
                drive_reg <= addressed; // RULE9
                in_frame_reg <= 1'b0; // RULE23
                load_cnt_reg <= `SSP_LOAD_DELAY;
            end else if (load_cnt_reg != 2'h0) begin
                load_cnt_reg <= load_cnt_reg - 2'h1;
                if (load_cnt_reg == 2'h1) begin
                    out_sr_reg <= rb_word; // RULE6
                end
            end else if (sck_fall && !sen_s && bit_cnt_reg != 6'h0) begin
                out_sr_reg <= {out_sr_reg[22:0], 1'b0};
            end
            if (sen_fall) begin
                in_frame_reg <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Pin multiplexer and driver
    // ****************************************************************
    wire gpo_bit = gpo_sources[pin_ctl_reg[`SSP_GPO_SEL_MSB:`SSP_GPO_SEL_LSB]]; // RULE14
    wire readback_sel = drive_reg && in_frame_reg && !pin_ctl_reg[`SSP_AUTOMUX_DIS_BIT]; // RULE11 RULE23
    reg pin_val_reg;
    reg pin_en_reg;

    // Pin value and enable are registered; the value goes straight to the pin, but the enable is gated again by the value and pull-disable bits.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_val_reg <= 1'b0;
            pin_en_reg <= 1'b0; // RULE8
        end else begin
            pin_val_reg <= readback_sel ? out_sr_reg[23] : gpo_bit;
            pin_en_reg <= driver_reg[`SSP_MASTER_DRV_BIT] && // RULE12
                (pin_ctl_reg[`SSP_ALWAYS_ON_BIT] || (drive_reg && in_frame_reg)); // RULE10 RULE9
        end
    end

    assign shared_lock_readback_pin_o = pin_val_reg;
    // With one half disabled the pin only sinks or only sources, as an open-drain line needs.
    assign shared_lock_readback_pin_oe = pin_en_reg &&
        (pin_val_reg ? !pin_ctl_reg[`SSP_PULLUP_DIS_BIT] : !pin_ctl_reg[`SSP_PULLDN_DIS_BIT]); // RULE13
endmodule

// ===== dv/ssp_props.sv
`timescale 1ns/100ps
module ssp_props #(
    parameter POR_CYCLES = 20
) (
    input wire clk,
    input wire rst_n,
    input wire frame_strobe,
    input wire chip_enable_pin,
    input wire shared_lock_readback_pin_oe,
    input wire powered_down,
    input wire [5:0] block_enable,
    input wire [1:0] fractional_seed,
    input wire fractional_seed_reload,
    input wire port_ready
);
    // ****************************************************************
    // Ages of the last strobe rise and chip-enable change
    // ****************************************************************
    reg s_prev;
    reg c_prev;
    reg seen;
    reg [5:0] s_age;
    reg [5:0] c_age;
    reg [31:0] r_cnt;
    // Ages saturate so that an old event never looks recent again.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_prev <= 1'b1;
            c_prev <= chip_enable_pin;
            seen <= 1'b0;
            s_age <= 6'h3f;
            c_age <= 6'h3f;
            r_cnt <= 32'h0;
        end else begin
            s_prev <= frame_strobe;
            c_prev <= chip_enable_pin;
            seen <= seen | port_ready;
            s_age <= (frame_strobe & ~s_prev) ? 6'h0 : ((s_age == 6'h3f) ? s_age : s_age + 6'h1);
            c_age <= (chip_enable_pin != c_prev) ? 6'h0 : ((c_age == 6'h3f) ? c_age : c_age + 6'h1);
            r_cnt <= port_ready ? 32'h0 : r_cnt + 32'h1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_oe_after_reset: assert property ($rose(rst_n) |-> !shared_lock_readback_pin_oe [*8])
        else $error("pin driven right after reset");
    a_reload_pulse: assert property (fractional_seed_reload |=> !fractional_seed_reload)
        else $error("seed reload longer than one cycle");
    a_reload_ready: assert property (fractional_seed_reload |-> port_ready)
        else $error("commit while port not ready");
    a_reload_time: assert property (fractional_seed_reload |-> s_age >= 2 && s_age <= 8)
        else $error("seed reload not tied to strobe rise");
    a_seed_source: assert property ($changed(fractional_seed) |-> s_age <= 45)
        else $error("seed changed without a frame");
    a_pd_source: assert property ($changed(powered_down) |-> s_age <= 45 || c_age <= 6)
        else $error("power-down changed without cause");
    a_blocks_on: assert property (!powered_down |-> block_enable == 6'h3f)
        else $error("block off while powered up");
    a_ready_hold: assert property ($fell(port_ready) |-> !port_ready [*8])
        else $error("soft reset sweep too short");
    a_sweep_len: assert property ($fell(port_ready) && seen |-> ##[20:60] port_ready)
        else $error("soft reset sweep never ended");
    a_por_len: assert property ($rose(port_ready) && !seen |-> r_cnt >= POR_CYCLES + 32)
        else $error("power-on load finished early");
    cover property ($rose(shared_lock_readback_pin_oe));
    cover property ($fell(port_ready) && seen);
    cover property (powered_down && s_age == 6'h0);
endmodule

bind ssp_top ssp_props #(.POR_CYCLES(POR_CYCLES)) ssp_props_i (
    .clk(clk),
    .rst_n(rst_n),
    .frame_strobe(frame_strobe),
    .chip_enable_pin(chip_enable_pin),
    .shared_lock_readback_pin_oe(shared_lock_readback_pin_oe),
    .powered_down(powered_down),
    .block_enable(block_enable),
    .fractional_seed(fractional_seed),
    .fractional_seed_reload(fractional_seed_reload),
    .port_ready(port_ready)
);

// ===== dv/ssp_host.sv
`timescale 1ns/100ps
module ssp_host (
    input wire clk,
    input wire pin_o,
    input wire pin_oe,
    output reg serial_clk,
    output reg serial_data_in,
    output reg frame_strobe
);
    initial begin
        serial_clk = 1'b0;
        serial_data_in = 1'b0;
        frame_strobe = 1'b1;
    end
    // One 32-bit frame; the serial clock runs at 80 ns only inside it and rests low.
    task automatic frame(input [23:0] d, input [4:0] a, input [2:0] c, output [23:0] rb, output [23:0] oe);
        reg [31:0] w;
        integer i;
        begin
            w = {d, a, c};
            @(negedge clk);
            frame_strobe = 1'b0;
            repeat (8) @(negedge clk);
            for (i = 31; i >= 0; i = i - 1) begin
                serial_data_in = w[i];
                repeat (5) @(negedge clk);
                if (i >= 8) begin
                    // A released line floats to its pull-up level.
                    rb[i-8] = pin_oe ? pin_o : 1'b1;
                    oe[i-8] = pin_oe;
                end
                serial_clk = 1'b1;
                repeat (5) @(negedge clk);
                serial_clk = 1'b0;
            end
            // The data line is released; show the inverse so a stale bit cannot pass.
            serial_data_in = ~w[0];
            repeat (5) @(negedge clk);
            frame_strobe = 1'b1;
            repeat (8) @(negedge clk);
        end
    endtask
endmodule

// ===== dv/tb.sv
`timescale 1ns/100ps
module tb;
    // Arbitrary identifier value for this bench.
    localparam [23:0] ID = 24'h3c3c10;
    reg clk = 1'b0;
    reg rst_n = 1'b0;
    reg chip_enable_pin = 1'b1;
    reg [31:0] gpo_sources = 32'h0;
    wire sclk, sdi, strobe, pin_o, pin_oe, powered_down, reload, port_ready;
    wire [5:0] block_enable;
    wire [1:0] seed;
    integer n_errors = 0;
    integer check_count = 0;
    integer cyc = 0;
    integer n_rel = 0;
    integer n;
    reg [23:0] rb, oe;
    always #4 clk = ~clk;
    ssp_top #(.POR_CYCLES(20), .PART_ID(ID)) ssp_top_i (.clk(clk), .rst_n(rst_n), .serial_clk(sclk),
        .serial_data_in(sdi), .frame_strobe(strobe), .chip_enable_pin(chip_enable_pin),
        .gpo_sources(gpo_sources), .shared_lock_readback_pin_o(pin_o), .shared_lock_readback_pin_oe(pin_oe),
        .powered_down(powered_down), .block_enable(block_enable), .fractional_seed(seed),
        .fractional_seed_reload(reload), .port_ready(port_ready));
    ssp_host ssp_host_i (.clk(clk), .pin_o(pin_o), .pin_oe(pin_oe), .serial_clk(sclk),
        .serial_data_in(sdi), .frame_strobe(strobe));
    // ****************************************************************
    // Tasks
    // ****************************************************************
    task stop_test;
        begin
            $display("checks %0d errors %0d", check_count, n_errors);
            if (n_errors == 0 && check_count > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (reload === 1'b1)
            n_rel = n_rel + 1;
        if (cyc == 40000) begin
            n_errors = n_errors + 1;
            stop_test;
        end
    end
    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        begin
            check_count = check_count + 1;
            if (g !== e) begin
                n_errors = n_errors + 1;
                $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task automatic wr(input [4:0] a, input [23:0] d, input [2:0] c);
        ssp_host_i.frame(d, a, c, rb, oe);
    endtask
    // Two-frame read: select the target, then repeat the same write to collect it.
    task automatic rdc(input string nm, input [4:0] a, input [23:0] e);
        begin
            wr(5'h00, {19'h0, a}, 3'h0);
            wr(5'h00, {19'h0, a}, 3'h0);
            chk(nm, e, rb);
        end
    endtask
    task automatic ready;
        while (port_ready !== 1'b1) @(negedge clk);
    endtask
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        ready;
        chk("oe_idle", 24'h0, {23'h0, pin_oe});
        chk("blocks", 24'h3f, {18'h0, block_enable});
        rdc("part_id", 5'h00, ID);
        chk("rd_oe", 24'hffffff, oe);
        chk("oe_after", 24'h0, {23'h0, pin_oe});
        rdc("power", 5'h01, 24'h000002);
        rdc("pin_ctl", 5'h0f, 24'h000001);
        rdc("driver", 5'h08, 24'h000020);
        wr(5'h0c, 24'ha5c3f1, 3'h0);
        rdc("mem", 5'h0c, 24'ha5c3f1);
        wr(5'h06, 24'h000002, 3'h0);
        chk("seed", 24'h2, {22'h0, seed});
        wr(5'h06, 24'h000001, 3'h5);
        chk("seed_foreign", 24'h2, {22'h0, seed});
        wr(5'h06, 24'h000001, 3'h5);
        chk("foreign_oe", 24'h0, oe);
        wr(5'h03, 24'h000046, 3'h0);
        n = n_rel;
        wr(5'h04, 24'h19999a, 3'h0);
        chk("reload", n + 1, n_rel);
        rdc("int_word", 5'h03, 24'h000046);
        chip_enable_pin = 1'b0;
        wr(5'h01, 24'h000005, 3'h0);
        chk("pd_pin", 24'h1, {23'h0, powered_down});
        chk("keep", 24'h01, {18'h0, block_enable});
        rdc("pd_read", 5'h01, 24'h000005);
        chip_enable_pin = 1'b1;
        repeat (6) @(negedge clk);
        chk("pd_pin_up", 24'h0, {23'h0, powered_down});
        wr(5'h01, 24'h000000, 3'h0);
        chk("pd_sw", 24'h1, {23'h0, powered_down});
        wr(5'h01, 24'h000002, 3'h0);
        chk("pd_sw_up", 24'h0, {23'h0, powered_down});
        gpo_sources = 32'h2;
        wr(5'h0f, 24'h000081, 3'h0);
        chk("on_oe", 24'h1, {23'h0, pin_oe});
        chk("on_val", 24'h1, {23'h0, pin_o});
        wr(5'h0f, 24'h000181, 3'h0);
        chk("pu_dis", 24'h0, {23'h0, pin_oe});
        gpo_sources = 32'h0;
        repeat (6) @(negedge clk);
        chk("pu_dis_low", 24'h1, {23'h0, pin_oe});
        wr(5'h0f, 24'h000281, 3'h0);
        chk("pd_dis", 24'h0, {23'h0, pin_oe});
        wr(5'h0f, 24'h000081, 3'h0);
        wr(5'h08, 24'h000000, 3'h0);
        chk("master_off", 24'h0, {23'h0, pin_oe});
        wr(5'h08, 24'h000020, 3'h0);
        gpo_sources = 32'h2;
        wr(5'h0f, 24'h0000c1, 3'h0);
        rdc("automux", 5'h0c, 24'hffffff);
        wr(5'h00, 24'h000020, 3'h0);
        chk("sr_busy", 24'h0, {23'h0, port_ready});
        ready;
        chk("sr_seed", 24'h0, {22'h0, seed});
        chk("sr_oe", 24'h0, {23'h0, pin_oe});
        rdc("sr_pin", 5'h0f, 24'h000001);
        rdc("sr_mem", 5'h0c, 24'h000000);
        stop_test;
    end
endmodule
